/* wakeup_pkg.sv */
// Purpose: shared constants for the wake-up timer block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: register indices are multiplied by four to form byte addresses
package wakeup_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h23;
  localparam logic [7:0] RELOAD_HIGH_IDX = 8'h24;
  localparam logic [7:0] RELOAD_LOW_IDX = 8'h25;
  localparam logic [7:0] COUNT_HIGH_IDX = 8'h26;
  localparam logic [7:0] COUNT_LOW_IDX = 8'h27;
  localparam logic [7:0] STATUS_IDX = 8'h30;

  // control field positions
  localparam int RUNNING_BIT = 7;
  localparam int RUN_WRITE_ENABLE_BIT = 6;
  localparam int AUTO_OSC_TRIM_BIT = 5;
  localparam int AUTO_CARD_DETECT_BIT = 4;
  localparam int AUTO_RELOAD_BIT = 3;
  localparam int AUTO_ROUSE_BIT = 2;
  localparam int CLOCK_SELECT_LSB = 0;

  // status field positions
  localparam int UNDERFLOW_FLAG_BIT = 0;
  localparam int CARD_SEEN_BIT = 1;

  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // slow oscillator divide ratios
  localparam logic [5:0] DIV_SEL_00 = 6'h01;
  localparam logic [5:0] DIV_SEL_01 = 6'h08;
  localparam logic [5:0] DIV_SEL_10 = 6'h10;
  localparam logic [5:0] DIV_SEL_11 = 6'h20;

  function automatic logic [5:0] divide_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: divide_ratio = DIV_SEL_00;
      2'h1: divide_ratio = DIV_SEL_01;
      2'h2: divide_ratio = DIV_SEL_10;
      default: divide_ratio = DIV_SEL_11;
    endcase
  endfunction : divide_ratio

  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

endpackage : wakeup_pkg

/* wakeup_tick_if.sv */
// Purpose: carries run, clock select and tick between timer and prescaler
// Assumes: both ends on core_clk
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
interface wakeup_tick_if;
  logic run;
  logic [1:0] sel;
  logic tick;
  modport timer (output run, output sel, input tick);
  modport presc (input run, input sel, output tick);
endinterface : wakeup_tick_if

/* wakeup_prescaler.sv */
// Purpose: turns slow oscillator edges into divided timer ticks
// Assumes: slow_oscillator is synchronous to core_clk and much slower
// Notes: divider restarts whenever the timer is stopped
`timescale 1ns/1ps
module wakeup_prescaler (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_oscillator,
  wakeup_tick_if.presc t
);

  typedef struct packed {
    logic osc_prev;
    logic [5:0] cnt;
    logic tick;
  } presc_state_t;

  presc_state_t s_q;
  presc_state_t s_d;
  logic edge_seen;
  logic [5:0] ratio;

  always_comb begin
    s_d = s_q;
    s_d.osc_prev = slow_oscillator;
    s_d.tick = 1'b0;
    edge_seen = slow_oscillator & ~s_q.osc_prev;
    ratio = wakeup_pkg::divide_ratio(t.sel);
    if (!t.run) begin
      s_d.cnt = 6'h00;
    end else if (edge_seen) begin
      if (s_q.cnt >= ratio - 6'h01) begin // [RULE_14]
        s_d.cnt = 6'h00;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.tick = s_q.tick;

  property p_tick_needs_edge;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.tick |-> $past(t.run) && $past(edge_seen);
  endproperty
  a_tick_needs_edge: assert property (p_tick_needs_edge) else $error("tick without oscillator edge"); // [RULE_14]

endmodule : wakeup_prescaler

/* wakeup_timer.sv */
// Purpose: 16-bit down-counting wake-up timer with trim and card detect launch
// Assumes: APB slave, one wait state per transfer, slow oscillator sampled
// Notes: procedures it launches run outside; it only sends requests
//
// How it works
// RULE_01: wakes device, launches card detection when enabled
// RULE_02: control bit 7 shows timer running
// RULE_03: running bit changes only with bit 6
// RULE_04: auto-trim launches oscillator trim at underflow
// RULE_05: software sets up a trim timer first
// RULE_06: card detect at underflow; card raises request
// RULE_07: no card returns to power-down if enabled
// RULE_08: card detect reloads at underflow without gap
// RULE_09: timer three times field during presence check
// RULE_10: auto-reload restarts from reload, else stops
// RULE_11: underflow sets the wake-up interrupt flag
// RULE_12: auto-rouse wakes device at every underflow
// RULE_13: software picks rouse bit for power-down re-entry
// RULE_14: clock select divides slow oscillator 1/8/16/32
// RULE_15: reload value copied into counter at start
// RULE_16: reload writes wait for next start event
// RULE_17: live count readable at high, low bytes
// RULE_18: decrement per tick; underflow decrementing at zero
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module wakeup_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_oscillator,
  input wire logic card_detect_done,
  input wire logic card_present,
  output logic wake_request,
  output logic osc_trim_start,
  output logic card_detect_start,
  output logic card_irq_request,
  output logic power_down_request,
  output logic field_timer_claim,
  output logic underflow_pulse
);

  typedef struct packed {
    logic running;
    logic auto_trim;
    logic auto_cd;
    logic auto_reload;
    logic auto_rouse;
    logic [1:0] clk_sel;
    logic [15:0] reload;
    logic [15:0] count;
    logic flag;
    logic card_seen;
    logic cd_busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic underflow;
    logic wake;
    logic trim_start;
    logic cd_start;
    logic card_irq;
    logic pd_req;
    logic field_claim;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;
  logic access;
  logic finish;
  logic wr;
  logic start_now;
  logic [7:0] ctrl_view;

  wakeup_tick_if t ();

  wakeup_prescaler u_presc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .slow_oscillator(slow_oscillator),
    .t(t)
  );

  assign t.run = s_q.running;
  assign t.sel = s_q.clk_sel;

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[wakeup_pkg::RUNNING_BIT] = s_q.running; // [RULE_02]
    ctrl_view[wakeup_pkg::AUTO_OSC_TRIM_BIT] = s_q.auto_trim;
    ctrl_view[wakeup_pkg::AUTO_CARD_DETECT_BIT] = s_q.auto_cd;
    ctrl_view[wakeup_pkg::AUTO_RELOAD_BIT] = s_q.auto_reload;
    ctrl_view[wakeup_pkg::AUTO_ROUSE_BIT] = s_q.auto_rouse;
    ctrl_view[wakeup_pkg::CLOCK_SELECT_LSB +: 2] = s_q.clk_sel;
  end

  always_comb begin
    s_d = s_q;
    access = psel & penable;
    finish = access & s_q.pready;
    wr = finish & pwrite & ~s_q.pslverr;
    start_now = 1'b0;
    s_d.underflow = 1'b0;
    s_d.wake = 1'b0;
    s_d.trim_start = 1'b0;
    s_d.cd_start = 1'b0;
    s_d.card_irq = 1'b0;
    s_d.pd_req = 1'b0;
    // field timer stays reserved while card detect is armed
    s_d.field_claim = s_q.auto_cd; // [RULE_09]

    // one wait state gives the read mux a full cycle
    s_d.pready = access & ~s_q.pready;
    if (access && !s_q.pready) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::CTRL_IDX)) begin
        s_d.prdata[7:0] = ctrl_view;
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::RELOAD_HIGH_IDX)) begin
        s_d.prdata[7:0] = s_q.reload[15:8];
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::RELOAD_LOW_IDX)) begin
        s_d.prdata[7:0] = s_q.reload[7:0];
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::COUNT_HIGH_IDX)) begin
        s_d.prdata[7:0] = s_q.count[15:8]; // [RULE_17]
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::COUNT_LOW_IDX)) begin
        s_d.prdata[7:0] = s_q.count[7:0]; // [RULE_17]
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::STATUS_IDX)) begin
        s_d.prdata[wakeup_pkg::UNDERFLOW_FLAG_BIT] = s_q.flag;
        s_d.prdata[wakeup_pkg::CARD_SEEN_BIT] = s_q.card_seen;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end else if (!access) begin
      s_d.pslverr = 1'b0;
    end

    if (wr) begin
      if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::CTRL_IDX)) begin
        s_d.auto_trim = pwdata[wakeup_pkg::AUTO_OSC_TRIM_BIT];
        s_d.auto_cd = pwdata[wakeup_pkg::AUTO_CARD_DETECT_BIT];
        s_d.auto_reload = pwdata[wakeup_pkg::AUTO_RELOAD_BIT];
        s_d.auto_rouse = pwdata[wakeup_pkg::AUTO_ROUSE_BIT];
        s_d.clk_sel = pwdata[wakeup_pkg::CLOCK_SELECT_LSB +: 2];
        if (pwdata[wakeup_pkg::RUN_WRITE_ENABLE_BIT]) begin // [RULE_03]
          s_d.running = pwdata[wakeup_pkg::RUNNING_BIT];
          start_now = pwdata[wakeup_pkg::RUNNING_BIT];
          if (start_now) begin
            s_d.count = s_q.reload; // [RULE_15]
          end
        end
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::RELOAD_HIGH_IDX)) begin
        s_d.reload[15:8] = pwdata[7:0]; // [RULE_16]
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::RELOAD_LOW_IDX)) begin
        s_d.reload[7:0] = pwdata[7:0]; // [RULE_16]
      end else if (wakeup_pkg::reg_hit(paddr, wakeup_pkg::STATUS_IDX)) begin
        if (pwdata[wakeup_pkg::UNDERFLOW_FLAG_BIT]) begin
          s_d.flag = 1'b0;
        end
        if (pwdata[wakeup_pkg::CARD_SEEN_BIT]) begin
          s_d.card_seen = 1'b0;
        end
      end
    end

    // tick handling follows the writes so a set beats a clear
    if (s_d.running && t.tick && !start_now) begin
      if (s_q.count == 16'h0000) begin // [RULE_18]
        s_d.underflow = 1'b1;
        s_d.flag = 1'b1; // [RULE_11]
        s_d.wake = s_q.auto_rouse; // [RULE_12] [RULE_01]
        s_d.trim_start = s_q.auto_trim; // [RULE_04]
        s_d.cd_start = s_q.auto_cd; // [RULE_06] [RULE_01]
        if (s_q.auto_cd) begin
          s_d.cd_busy = 1'b1;
        end
        if (s_q.auto_reload || s_q.auto_cd) begin // [RULE_10] [RULE_08]
          s_d.count = s_q.reload;
        end else begin
          s_d.running = 1'b0; // [RULE_10]
        end
      end else begin
        s_d.count = s_q.count - 16'h0001; // [RULE_18]
      end
    end

    // the sequence outcome, using timer three for the field window
    if (s_q.cd_busy && card_detect_done) begin
      s_d.cd_busy = 1'b0;
      if (card_present) begin
        s_d.card_irq = 1'b1; // [RULE_06]
        s_d.card_seen = 1'b1;
      end else if (s_q.auto_rouse) begin
        s_d.pd_req = 1'b1; // [RULE_07]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.auto_trim <= wakeup_pkg::CTRL_RESET[wakeup_pkg::AUTO_OSC_TRIM_BIT];
      s_q.reload <= wakeup_pkg::RELOAD_RESET;
      s_q.count <= wakeup_pkg::COUNT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign wake_request = s_q.wake;
  assign osc_trim_start = s_q.trim_start;
  assign card_detect_start = s_q.cd_start;
  assign card_irq_request = s_q.card_irq;
  assign power_down_request = s_q.pd_req;
  assign field_timer_claim = s_q.field_claim;
  assign underflow_pulse = s_q.underflow;

  logic ctrl_wr;
  logic reload_wr;
  assign ctrl_wr = wr && wakeup_pkg::reg_hit(paddr, wakeup_pkg::CTRL_IDX);
  assign reload_wr = wr && (wakeup_pkg::reg_hit(paddr, wakeup_pkg::RELOAD_HIGH_IDX) ||
                            wakeup_pkg::reg_hit(paddr, wakeup_pkg::RELOAD_LOW_IDX));

  sequence s_cd_no_card;
    s_q.cd_busy && card_detect_done && !card_present && s_q.auto_rouse;
  endsequence

  sequence s_pd_follows;
    s_q.pd_req ##1 !s_q.pd_req;
  endsequence

  property p_flag_on_underflow;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.underflow |-> s_q.flag;
  endproperty
  a_flag_on_underflow: assert property (p_flag_on_underflow) else $error("underflow left flag clear"); // [RULE_11]

  property p_run_kept;
    @(posedge core_clk) disable iff (!rst_n)
    ctrl_wr && !pwdata[wakeup_pkg::RUN_WRITE_ENABLE_BIT] && !(t.tick && s_q.count == 16'h0000) |=>
      s_q.running == $past(s_q.running);
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("running changed without write enable"); // [RULE_03]

  property p_start_loads;
    @(posedge core_clk) disable iff (!rst_n)
    ctrl_wr && pwdata[wakeup_pkg::RUNNING_BIT] && pwdata[wakeup_pkg::RUN_WRITE_ENABLE_BIT] |=>
      s_q.running && s_q.count == $past(s_q.reload);
  endproperty
  a_start_loads: assert property (p_start_loads) else $error("start did not load reload"); // [RULE_15]

  property p_reload_no_disturb;
    @(posedge core_clk) disable iff (!rst_n)
    reload_wr && !t.tick |=> s_q.count == $past(s_q.count);
  endproperty
  a_reload_no_disturb: assert property (p_reload_no_disturb) else $error("reload write moved count"); // [RULE_16]

  property p_trim_launch;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.underflow |-> s_q.trim_start == s_q.auto_trim;
  endproperty
  a_trim_launch: assert property (p_trim_launch) else $error("trim launch mismatch"); // [RULE_04]

  property p_cd_no_gap;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.underflow && s_q.auto_cd |-> s_q.cd_start && s_q.running && s_q.count == $past(s_q.reload);
  endproperty
  a_cd_no_gap: assert property (p_cd_no_gap) else $error("card detect reload gap"); // [RULE_08]

  property p_wake_launch;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(s_q.underflow) |-> s_q.wake == s_q.auto_rouse ##1 !s_q.wake || s_q.underflow;
  endproperty
  a_wake_launch: assert property (p_wake_launch) else $error("wake request mismatch"); // [RULE_12]

  property p_power_down;
    @(posedge core_clk) disable iff (!rst_n)
    s_cd_no_card |=> s_pd_follows;
  endproperty
  a_power_down: assert property (p_power_down) else $error("no power-down after empty detect"); // [RULE_07]

  property p_decrement;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.running && t.tick && s_q.count != 16'h0000 && !ctrl_wr |=> s_q.count == $past(s_q.count) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement"); // [RULE_18]

  property p_one_shot_stop;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.underflow && !s_q.auto_reload && !s_q.auto_cd && !$past(ctrl_wr) |-> !s_q.running;
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("timer kept running"); // [RULE_10]

  property p_claim_follows;
    @(posedge core_clk) disable iff (!rst_n)
    s_q.field_claim == $past(s_q.auto_cd);
  endproperty
  a_claim_follows: assert property (p_claim_follows) else $error("field timer claim not tracking"); // [RULE_09]

endmodule : wakeup_timer

/* wakeup_timer_low_power_card_detection_trigger_tb_top.sv */
// Purpose: self-checking bench for the wake-up timer block
// Assumes: apb may answer after any number of wait states; ticks come on every nth slow edge
// Notes: apb results go through a note queue; event pulses are counted
`timescale 1ns/1ps
module wakeup_timer_low_power_card_detection_trigger_tb_top;
  typedef struct {logic [31:0] data; logic chk; logic err;} note_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic slow_oscillator = 1'b0;
  logic card_detect_done = 1'b0;
  logic card_present = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wake_request, osc_trim_start, card_detect_start;
  logic card_irq_request, power_down_request, field_timer_claim, underflow_pulse;
  logic [5:0] outs;
  note_t notes[$];
  int pc[6];
  int miscompares = 0;
  int cmp_count = 0;
  int divs[4] = '{1, 8, 16, 32};

  always #10 core_clk = ~core_clk;

  wakeup_timer DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_oscillator(slow_oscillator), .card_detect_done(card_detect_done), .card_present(card_present),
    .wake_request(wake_request), .osc_trim_start(osc_trim_start), .card_detect_start(card_detect_start),
    .card_irq_request(card_irq_request), .power_down_request(power_down_request),
    .field_timer_claim(field_timer_claim), .underflow_pulse(underflow_pulse));

  assign outs = {power_down_request, card_irq_request, card_detect_start, osc_trim_start, wake_request,
    underflow_pulse};

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // apb result monitor: oldest note against the completed transfer
  always @(posedge core_clk) begin
    note_t n;
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        if (n.chk) begin
          check(prdata, n.data);
        end
        check({31'h0, pslverr}, {31'h0, n.err});
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst_n) begin
      for (int i = 0; i < 6; i++) begin
        pc[i] += int'(outs[i]);
      end
    end
  end

  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp,
                     input logic err);
    note_t n;
    n.data = {24'h0, exp};
    n.chk = !w && !err;
    n.err = err;
    notes.push_back(n);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // no assumed latency; only the watchdog ends a hung wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~{24'h0, d};
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, d, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {idx, 2'b00}, 8'h00, exp, 1'b0);
  endtask : rd

  // one slow edge every four core cycles, then let the tick pipeline drain
  task automatic ticks(input int n, input int div);
    repeat (n * div) begin
      @(posedge core_clk) slow_oscillator <= 1'b1;
      repeat (2) @(posedge core_clk);
      slow_oscillator <= 1'b0;
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask : ticks

  task automatic done(input logic p);
    @(posedge core_clk);
    card_detect_done <= 1'b1;
    card_present <= p;
    @(posedge core_clk);
    card_detect_done <= 1'b0;
    card_present <= ~p;
    repeat (3) @(posedge core_clk);
  endtask : done

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    final_report();
  end

  initial begin
    logic [7:0] r;
    void'($urandom(32'h911d));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, read-only count, refused addresses
    rd(wakeup_pkg::CTRL_IDX, 8'h00);
    rd(wakeup_pkg::COUNT_HIGH_IDX, 8'h00);
    r = 8'($urandom());
    wr(wakeup_pkg::RELOAD_HIGH_IDX, r);
    rd(wakeup_pkg::RELOAD_HIGH_IDX, r);
    wr(wakeup_pkg::COUNT_LOW_IDX, 8'h55);
    rd(wakeup_pkg::COUNT_LOW_IDX, 8'h00);
    apb(1'b0, 10'h0c4, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 10'h08d, 8'hc0, 8'h00, 1'b1);
    wr(wakeup_pkg::CTRL_IDX, 8'h88);
    rd(wakeup_pkg::CTRL_IDX, 8'h08);
    // each clock select: start, partial count, reload write, run down
    for (int s = 0; s < 4; s++) begin
      r = 8'(2 + $urandom_range(3));
      wr(wakeup_pkg::RELOAD_HIGH_IDX, 8'h00);
      wr(wakeup_pkg::RELOAD_LOW_IDX, r);
      wr(wakeup_pkg::CTRL_IDX, 8'hc0 | 8'(s));
      rd(wakeup_pkg::CTRL_IDX, 8'h80 | 8'(s));
      rd(wakeup_pkg::COUNT_LOW_IDX, r);
      ticks(1, divs[s]);
      rd(wakeup_pkg::COUNT_LOW_IDX, r - 8'h01);
      wr(wakeup_pkg::RELOAD_LOW_IDX, 8'h7f);
      rd(wakeup_pkg::COUNT_LOW_IDX, r - 8'h01);
      ticks(int'(r), divs[s]);
      rd(wakeup_pkg::CTRL_IDX, 8'(s));
      rd(wakeup_pkg::STATUS_IDX, 8'h01);
      wr(wakeup_pkg::STATUS_IDX, 8'h03);
      check(32'(pc[0]), 32'(s + 1));
    end
    check(32'(pc[1] + pc[2] + pc[3]), 32'h0);
    // every launch enabled, auto reload with no gap
    wr(wakeup_pkg::RELOAD_LOW_IDX, 8'h01);
    // trim timer assumed set up outside; rouse set so an empty detect re-enters power-down
    wr(wakeup_pkg::CTRL_IDX, 8'hfc);
    ticks(2, 1);
    rd(wakeup_pkg::COUNT_LOW_IDX, 8'h01);
    rd(wakeup_pkg::CTRL_IDX, 8'hbc);
    check(32'(pc[1]), 32'h1);
    check(32'(pc[2]), 32'h1);
    check(32'(pc[3]), 32'h1);
    check({31'h0, field_timer_claim}, 32'h1);
    done(1'b1);
    check(32'(pc[4]), 32'h1);
    rd(wakeup_pkg::STATUS_IDX, 8'h03);
    wr(wakeup_pkg::STATUS_IDX, 8'h03);
    ticks(2, 1);
    done(1'b0);
    check(32'(pc[5]), 32'h1);
    check(32'(pc[4]), 32'h1);
    check(32'(pc[0]), 32'h6);
    wr(wakeup_pkg::CTRL_IDX, 8'h40);
    rd(wakeup_pkg::CTRL_IDX, 8'h00);
    repeat (3) @(posedge core_clk);
    check({31'h0, field_timer_claim}, 32'h0);
    final_report();
  end
endmodule : wakeup_timer_low_power_card_detection_trigger_tb_top
